// *** hw/wdtw_top.sv ***
// Purpose: Windowed watchdog timer with register port and core event inputs
// Assumes: Core event inputs come from logic on i_core_clk; i_rst_n is power-on reset
// Notes:   The oscillator is modelled as a tick divided from the core clock
`timescale 1ns/10ps
`default_nettype none
`include "wdtw_consts.svh"
module wdtw_top #(
  parameter int P_OSC_DIV = `WDTW_OSC_DIV
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_watchdog_clear_instr,
  input  wire logic        i_power_save_instr,
  input  wire logic        i_power_save_idle,
  input  wire logic        i_clk_switch_done,
  input  wire logic        i_dev_reset,
  input  wire logic        i_wake_event,
  output logic             o_low_power_rc_osc_enable,
  output logic             o_wdt_reset_req,
  output logic             o_wake
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  localparam logic [7:0]     CFG_RESET = `WDTW_CONFIG_RESET; // Named so its bits can be selected
  logic [9:0]                osc_div_q;
  logic                      osc_tick;
  logic                      soft_en_q;
  logic                      timeout_flag_q;
  logic                      sleep_flag_q;
  logic                      idle_flag_q;
  logic [3:0]                post_sel_q;
  logic                      pre_sel_q;
  logic                      window_disable_q;
  logic                      hard_en_q;
  wdtw_pkg::wdtw_pmode_t     pmode_q;
  wdtw_pkg::wdtw_pmode_t     pmode_d;
  logic [31:0]               rdata_q;
  logic                      reset_req_q;
  logic                      wake_q;
  logic                      run;
  logic                      in_low_power;
  logic                      clr_instr;
  logic                      enter_lp;
  logic                      exit_lp;
  logic                      early_clear;
  logic                      scaler_clear;
  logic                      timeout;
  logic                      timeout_evt;
  logic                      window_open;
  logic [6:0]                pre_cnt;
  logic [14:0]               post_cnt;
  logic                      we_status;
  logic                      we_config;
  logic [31:0]               rd_mux;

  // ----------------------------------------------------------------------------
  // Enable and core events
  // ----------------------------------------------------------------------------
  // Hard enable overrides soft enable, so clearing soft enable cannot stop a forced watchdog
  assign run               = hard_en_q | soft_en_q;
  assign o_low_power_rc_osc_enable = run;
  assign in_low_power      = (pmode_q != wdtw_pkg::WDTW_RUN);
  // Clear only counts during normal execution
  assign clr_instr         = i_watchdog_clear_instr & ~in_low_power;
  assign enter_lp          = i_power_save_instr & ~in_low_power & ~i_dev_reset; // Reset wins
  // A clear arriving with a time-out wins, since the core did service it
  assign timeout_evt       = timeout & ~clr_instr & ~i_dev_reset & ~i_clk_switch_done
                             & ~enter_lp;
  assign exit_lp           = in_low_power & (i_wake_event | timeout_evt);
  assign early_clear       = clr_instr & run & ~window_disable_q & ~window_open;

  // Every clearing event, and a stopped watchdog, restarts the whole chain
  assign scaler_clear = ~run | i_dev_reset
                        | i_clk_switch_done
                        | enter_lp
                        | exit_lp
                        | clr_instr;

  // ----------------------------------------------------------------------------
  // Low-power oscillator model
  // ----------------------------------------------------------------------------
  // Runs only while the watchdog is on, saving power otherwise
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !run) begin
      osc_div_q <= 10'h000;
    end else if (osc_div_q == 10'(P_OSC_DIV - 1)) begin
      osc_div_q <= 10'h000;
    end else begin
      osc_div_q <= osc_div_q + 10'h001;
    end
  end
  assign osc_tick = run & (osc_div_q == 10'(P_OSC_DIV - 1));

  // ----------------------------------------------------------------------------
  // Prescaler and postscaler
  // ----------------------------------------------------------------------------
  wdtw_scaler u_scaler (
    .i_core_clk    (i_core_clk),
    .i_rst_n       (i_rst_n),
    .i_tick        (osc_tick),
    .i_clear       (scaler_clear),
    .i_pre_sel     (pre_sel_q),
    .i_post_sel    (post_sel_q),
    .o_timeout     (timeout),
    .o_window_open (window_open),
    .o_pre_cnt     (pre_cnt),
    .o_post_cnt    (post_cnt)
  );

  // ----------------------------------------------------------------------------
  // Power mode tracking
  // ----------------------------------------------------------------------------
  always_comb begin
    pmode_d = pmode_q;
    unique case (pmode_q)
      wdtw_pkg::WDTW_RUN: begin
        if (enter_lp) begin
          pmode_d = i_power_save_idle ? wdtw_pkg::WDTW_IDLE : wdtw_pkg::WDTW_SLEEP;
        end
      end
      wdtw_pkg::WDTW_SLEEP, wdtw_pkg::WDTW_IDLE: begin
        // Time-out here resumes execution rather than resetting
        if (exit_lp) begin
          pmode_d = wdtw_pkg::WDTW_RUN;
        end
      end
      default: begin
        pmode_d = wdtw_pkg::WDTW_RUN;
      end
    endcase
  end

  // Device reset always returns the core to normal execution
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_dev_reset) begin
      pmode_q <= wdtw_pkg::WDTW_RUN;
    end else begin
      pmode_q <= pmode_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Time-out outcomes
  // ----------------------------------------------------------------------------
  // Reset request for a time-out in run mode or a clear outside the window
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= (timeout_evt & ~in_low_power) | early_clear;
    end
  end
  assign o_wdt_reset_req = reset_req_q;

  // Wake pulse for a time-out in sleep or idle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= timeout_evt & in_low_power;
    end
  end
  assign o_wake = wake_q;

  // ----------------------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------------------
  assign we_status = i_wr & (i_addr == `WDTW_ADDR_STATUS);
  assign we_config = i_wr & (i_addr == `WDTW_ADDR_CONFIG);

  // Soft enable dies with any device reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_dev_reset) begin
      soft_en_q <= 1'b0;
    end else if (we_status) begin
      soft_en_q <= i_wdata[`WDTW_ST_SOFT_EN];
    end
  end

  // Flag survives the reset it causes; only power-on or software clears it
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      timeout_flag_q <= 1'b0;
    end else if (timeout_evt) begin
      timeout_flag_q <= 1'b1;
    end else if (we_status) begin
      timeout_flag_q <= i_wdata[`WDTW_ST_TIMEOUT];
    end
  end

  // Sleep and idle flags stay set until software writes them clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sleep_flag_q <= 1'b0;
      idle_flag_q  <= 1'b0;
    end else begin
      if (enter_lp && !i_power_save_idle) begin
        sleep_flag_q <= 1'b1;
      end else if (we_status) begin
        sleep_flag_q <= i_wdata[`WDTW_ST_SLEEP];
      end
      if (enter_lp && i_power_save_idle) begin
        idle_flag_q <= 1'b1;
      end else if (we_status) begin
        idle_flag_q <= i_wdata[`WDTW_ST_IDLE];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Configuration word
  // ----------------------------------------------------------------------------
  // Held in flops so software can stand in for fuse programming
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      post_sel_q       <= CFG_RESET[`WDTW_CFG_POST_LSB +: 4];
      pre_sel_q        <= CFG_RESET[`WDTW_CFG_PRE_SEL];
      window_disable_q <= CFG_RESET[`WDTW_CFG_WIN_DIS];
      hard_en_q        <= CFG_RESET[`WDTW_CFG_HARD_EN];
    end else if (we_config) begin
      post_sel_q       <= i_wdata[`WDTW_CFG_POST_LSB +: 4];
      pre_sel_q        <= i_wdata[`WDTW_CFG_PRE_SEL];
      window_disable_q <= i_wdata[`WDTW_CFG_WIN_DIS];
      hard_en_q        <= i_wdata[`WDTW_CFG_HARD_EN];
    end
  end

  // ----------------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_addr)
      `WDTW_ADDR_STATUS: begin
        rd_mux[`WDTW_ST_SOFT_EN] = soft_en_q;
        rd_mux[`WDTW_ST_TIMEOUT] = timeout_flag_q;
        rd_mux[`WDTW_ST_SLEEP]   = sleep_flag_q;
        rd_mux[`WDTW_ST_IDLE]    = idle_flag_q;
      end
      `WDTW_ADDR_CONFIG: begin
        rd_mux[`WDTW_CFG_POST_LSB +: 4] = post_sel_q;
        rd_mux[`WDTW_CFG_PRE_SEL]       = pre_sel_q;
        rd_mux[`WDTW_CFG_WIN_DIS]       = window_disable_q;
        rd_mux[`WDTW_CFG_HARD_EN]       = hard_en_q;
      end
      `WDTW_ADDR_COUNT: begin
        rd_mux[21:0] = {post_cnt, pre_cnt};
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_cleared;
    pre_cnt == 7'h00 && post_cnt == 15'h0000;
  endsequence

  property p_osc_quiet;
    !o_low_power_rc_osc_enable |-> !osc_tick ##1 osc_div_q == 10'h000;
  endproperty
  a_osc_quiet: assert property (p_osc_quiet) else $error("Tick while off");

  property p_pre_bound;
    !pre_sel_q && osc_tick |=> pre_cnt <= 7'h1f;
  endproperty
  a_pre_bound: assert property (p_pre_bound) else $error("Prescaler past 32");

  property p_dev_reset;
    i_dev_reset |=> s_cleared and !soft_en_q;
  endproperty
  a_dev_reset: assert property (p_dev_reset) else $error("Reset left counts");

  property p_clk_switch;
    i_clk_switch_done |=> s_cleared;
  endproperty
  a_clk_switch: assert property (p_clk_switch) else $error("Switch left counts");

  property p_enter_lp;
    enter_lp |=> s_cleared and in_low_power;
  endproperty
  a_enter_lp: assert property (p_enter_lp) else $error("Power save left counts");

  property p_exit_lp;
    exit_lp && !i_dev_reset |=> s_cleared and !in_low_power;
  endproperty
  a_exit_lp: assert property (p_exit_lp) else $error("Exit left counts");

  property p_clear_instr;
    clr_instr |=> s_cleared;
  endproperty
  a_clear_instr: assert property (p_clear_instr) else $error("Clear ignored");

  property p_lp_wake;
    timeout_evt && in_low_power |=> o_wake && !o_wdt_reset_req;
  endproperty
  a_lp_wake: assert property (p_lp_wake) else $error("No wake in sleep");

  property p_hard_on;
    hard_en_q |-> o_low_power_rc_osc_enable;
  endproperty
  a_hard_on: assert property (p_hard_on) else $error("Hard enable ignored");

  property p_soft_off;
    !hard_en_q && !soft_en_q |=> s_cleared and !o_wake;
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("Ran while disabled");

  property p_early;
    clr_instr && run && !window_disable_q && !window_open |=> o_wdt_reset_req;
  endproperty
  a_early: assert property (p_early) else $error("Early clear not punished");

  property p_flag_sticky;
    timeout_flag_q && !we_status |=> timeout_flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Flag self-cleared");

  property p_run_reset;
    timeout_evt && !in_low_power |=> o_wdt_reset_req && timeout_flag_q;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("Time-out not reset");

  property p_read_one;
    !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_read_one: assert property (p_read_one) else $error("Read data lingered");

  c_run_timeout: cover property (timeout_evt && !in_low_power);
  c_sleep_wake:  cover property (enter_lp ##[1:1000] o_wake);
  c_window_ok:   cover property (clr_instr && !window_disable_q && window_open);
  c_early_clear: cover property (early_clear);

endmodule : wdtw_top
`default_nettype wire

// *** hw/wdtw_consts.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the windowed watchdog
// Assumes: Included by bare name from the top and scaler source files; the package does not include it
// Notes:   Definitions only
`ifndef WDTW_CONSTS_SVH
`define WDTW_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDTW_CORE_FREQ_KHZ      20000
`define WDTW_OSC_FREQ_KHZ       32
`define WDTW_OSC_DIV            (`WDTW_CORE_FREQ_KHZ / `WDTW_OSC_FREQ_KHZ)
`define WDTW_BASE_PERIOD_32_MS  1
`define WDTW_BASE_PERIOD_128_MS 4
`define WDTW_PRE_LAST_32        (7'(`WDTW_OSC_FREQ_KHZ * `WDTW_BASE_PERIOD_32_MS - 1))
`define WDTW_PRE_LAST_128       (7'(`WDTW_OSC_FREQ_KHZ * `WDTW_BASE_PERIOD_128_MS - 1))

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WDTW_ADDR_STATUS        8'h00
`define WDTW_ADDR_CONFIG        8'h04
`define WDTW_ADDR_COUNT         8'h08

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define WDTW_ST_SOFT_EN         5
`define WDTW_ST_TIMEOUT         4
`define WDTW_ST_SLEEP           3
`define WDTW_ST_IDLE            2
`define WDTW_CFG_POST_LSB       0
`define WDTW_CFG_PRE_SEL        4
`define WDTW_CFG_WIN_DIS        6
`define WDTW_CFG_HARD_EN        7
`define WDTW_CONFIG_RESET       8'h5f

`endif

// *** hw/wdtw_pkg.sv ***
// Purpose: Types shared by the windowed watchdog
// Assumes: Nothing
// Notes:   Constants live in wdtw_consts.svh
package wdtw_pkg;

  // Power mode of the core as seen by the watchdog
  typedef enum logic [1:0] {
    WDTW_RUN   = 2'b00,
    WDTW_SLEEP = 2'b01,
    WDTW_IDLE  = 2'b10
  } wdtw_pmode_t;

endpackage : wdtw_pkg

// *** hw/wdtw_scaler.sv ***
// Purpose: Prescaler and postscaler chain of the watchdog, with window detection
// Assumes: i_tick is a one-cycle pulse per low-power oscillator period
// Notes:   Clear has priority over counting
`timescale 1ns/10ps
`default_nettype none
`include "wdtw_consts.svh"
module wdtw_scaler (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_tick,
  input  wire logic        i_clear,
  input  wire logic        i_pre_sel,
  input  wire logic [3:0]  i_post_sel,
  output logic             o_timeout,
  output logic             o_window_open,
  output logic [6:0]       o_pre_cnt,
  output logic [14:0]      o_post_cnt
);

  logic [6:0]  pre_cnt_q;
  logic [14:0] post_cnt_q;
  logic [6:0]  pre_last;
  logic [14:0] post_last;
  logic        pre_wrap;
  logic [21:0] elapsed;
  logic [4:0]  top_bit;

  // ----------------------------------------------------------------------------
  // Terminal counts
  // ----------------------------------------------------------------------------
  // Greater-or-equal so a shrinking selection mid-period cannot strand the count
  assign pre_last   = i_pre_sel ? `WDTW_PRE_LAST_128 : `WDTW_PRE_LAST_32;
  assign post_last  = 15'((16'h0001 << i_post_sel) - 16'h0001);
  assign pre_wrap   = i_tick & (pre_cnt_q >= pre_last);
  assign o_timeout  = pre_wrap & (post_cnt_q >= post_last);
  assign o_pre_cnt  = pre_cnt_q;
  assign o_post_cnt = post_cnt_q;

  // Prescaler, 5 or 7 bits used
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_clear) begin
      pre_cnt_q <= 7'h00;
    end else if (i_tick) begin
      pre_cnt_q <= pre_wrap ? 7'h00 : pre_cnt_q + 7'h01;
    end
  end

  // Postscaler steps once per prescaler wrap
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_clear) begin
      post_cnt_q <= 15'h0000;
    end else if (pre_wrap) begin
      post_cnt_q <= o_timeout ? 15'h0000 : post_cnt_q + 15'h0001;
    end
  end

  // ----------------------------------------------------------------------------
  // Window: last quarter means both top bits of elapsed time are set
  // ----------------------------------------------------------------------------
  always_comb begin
    elapsed = i_pre_sel ? {post_cnt_q, pre_cnt_q} : {2'b00, post_cnt_q, pre_cnt_q[4:0]};
    top_bit = {1'b0, i_post_sel} + (i_pre_sel ? 5'h07 : 5'h05);
  end
  assign o_window_open = elapsed[top_bit - 5'h01] & elapsed[top_bit - 5'h02];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_post_restart;
    o_timeout && !i_clear |=> post_cnt_q == 15'h0000 && pre_cnt_q == 7'h00;
  endproperty
  a_post_restart: assert property (p_post_restart) else $error("Postscaler not restarted");

  property p_post_step;
    pre_wrap && !o_timeout && !i_clear |=> post_cnt_q == $past(post_cnt_q) + 15'h0001;
  endproperty
  a_post_step: assert property (p_post_step) else $error("Postscaler missed a step");

endmodule : wdtw_scaler
`default_nettype wire

// *** verif/wdtw_core_model.sv ***
// Purpose: Core model that issues clear, power-save and system event pulses
// Assumes: The bench calls pulse from its main sequence
// Notes:   Each pulse is one cycle and changes right after a rising edge
`timescale 1ns/10ps
`default_nettype none
module wdtw_core_model (
  input  wire logic i_core_clk,
  output logic      o_clear,
  output logic      o_psave,
  output logic      o_idle,
  output logic      o_switch,
  output logic      o_dev_rst,
  output logic      o_wake_evt
);
  logic [5:0] ev_q = '0;
  // ---------------------------------------------------------------
  // Event pulses
  // ---------------------------------------------------------------
  // Idle select is driven beside whichever pulse is issued, for its one cycle
  assign o_clear    = ev_q[0];
  assign o_psave    = ev_q[1];
  assign o_switch   = ev_q[2];
  assign o_dev_rst  = ev_q[3];
  assign o_wake_evt = ev_q[4];
  assign o_idle     = ev_q[5];

  task automatic pulse(input int k, input logic idl);
    @(posedge i_core_clk);
    ev_q <= 6'(1 << k) | {idl, 5'h00};
    @(posedge i_core_clk);
    ev_q <= '0;
  endtask : pulse
endmodule : wdtw_core_model
`default_nettype wire

// *** verif/wdtw_top_bench.sv ***
// Purpose: Self-checking bench for the windowed watchdog
// Assumes: Oscillator tick shortened to 4 core clocks
// Notes:   Periods are checked within one tick, the tick phase is free
`timescale 1ns/10ps
`default_nettype none
module wdtw_top_bench;
  localparam int P_DIV = 4;
  logic        i_core_clk, i_rst_n, i_wr, i_rd, clr, psv, idl, sw, drst, wk;
  logic        o_low_power_rc_osc_enable, o_wdt_reset_req, o_wake, w;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rv;
  int          mismatches = 0, cmp_count = 0, nreq = 0, seed = 32'h5d41826f;
  int          n, k, c, pre, post, r0;

  wdtw_core_model core (.i_core_clk(i_core_clk), .o_clear(clr), .o_psave(psv),
    .o_idle(idl), .o_switch(sw), .o_dev_rst(drst), .o_wake_evt(wk));
  wdtw_top #(.P_OSC_DIV(P_DIV)) dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_watchdog_clear_instr(clr), .i_power_save_instr(psv), .i_power_save_idle(idl),
    .i_clk_switch_done(sw), .i_dev_reset(drst), .i_wake_event(wk),
    .o_low_power_rc_osc_enable(o_low_power_rc_osc_enable),
    .o_wdt_reset_req(o_wdt_reset_req), .o_wake(o_wake));

  // ---------------------------------------------------------------
  // Clock, reset-request counter and helpers
  // ---------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) if (o_wdt_reset_req === 1'b1) nreq++;

  function automatic int exp_per(input int p, input int s);
    return (P_DIV * (p ? 128 : 32)) << s;
  endfunction : exp_per

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  // Bounded wait for a reset request or a wake
  task automatic wait_evt(input int mx, output int cy, output logic wo);
    cy = 0;
    while (cy < mx && o_wdt_reset_req !== 1'b1 && o_wake !== 1'b1) begin
      @(posedge i_core_clk);
      #1 cy++;
    end
    wo = o_wake;
    if (cy >= mx) begin
      mismatches++;
      close_out();
    end
  endtask : wait_evt

  initial begin
    #(50 * 100000) mismatches++;
    close_out();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    #1 chk("osc_en", o_low_power_rc_osc_enable, 0);
    rd(8'h04, rv);
    chk("cfg_reset", rv, 32'h5f);
    rd(8'h0c, rv);
    chk("unmapped", rv, 0);
    // Random divider settings, first pass at the shortest period
    for (n = 0; n < 5; n++) begin
      pre  = n ? $random(seed) & 1 : 0;
      post = n ? $random(seed) & 3 : 0;
      wr(8'h04, 32'hc0 | (pre << 4) | post);
      #1 chk("osc_en", o_low_power_rc_osc_enable, 1);
      core.pulse(0, 1'b0);
      wait_evt(5000, c, w);
      chk("period", 32'(c >= exp_per(pre, post) - P_DIV && c <= exp_per(pre, post) + P_DIV + 2), 1);
      chk("run_wake", w, 0);
      rd(8'h00, rv);
      chk("flag_set", rv[4], 1);
      wr(8'h00, 0);
      rd(8'h00, rv);
      chk("flag_clr", rv[4], 0);
    end
    // Periodic clears hold off the reset; clears and switches zero counts
    r0 = nreq;
    for (n = 0; n < 10; n++) begin
      repeat (90) @(posedge i_core_clk);
      core.pulse(n & 1 ? 2 : 0, 1'b0);
      rd(8'h08, rv);
      chk("cnt_zero", 32'(rv < 2), 1);
    end
    chk("no_req", nreq - r0, 0);
    // Window mode: early clear resets, late clear is accepted
    wr(8'h04, 32'h80);
    for (n = 0; n < 2; n++) begin
      core.pulse(2, 1'b0);
      r0 = nreq;
      repeat ((n ? 26 : 20) * P_DIV) @(posedge i_core_clk);
      core.pulse(0, 1'b0);
      repeat (3) @(posedge i_core_clk);
      chk("win_req", nreq - r0, n ? 0 : 1);
    end
    // Sleep then idle: entry zeroes counts, time-out wakes
    wr(8'h04, 32'hc0);
    for (k = 0; k < 2; k++) begin
      core.pulse(1, k[0]);
      rd(8'h08, rv);
      chk("psv_cnt", 32'(rv < 2), 1);
      r0 = nreq;
      wait_evt(400, c, w);
      chk("wake", w, 1);
      chk("no_reset", nreq - r0, 0);
      rd(8'h00, rv);
      chk("mode_flag", rv[3:2], k ? 2'b01 : 2'b10);
      wr(8'h00, 0);
    end
    // Wake by another source zeroes counts
    core.pulse(1, 1'b0);
    repeat (60) @(posedge i_core_clk);
    core.pulse(4, 1'b0);
    rd(8'h08, rv);
    chk("exit_cnt", 32'(rv < 2), 1);
    // Soft enable only when hard enable is off
    wr(8'h04, 32'h40);
    #1 chk("soft_off", o_low_power_rc_osc_enable, 0);
    wr(8'h00, 32'h20);
    #1 chk("soft_on", o_low_power_rc_osc_enable, 1);
    repeat (60) @(posedge i_core_clk);
    core.pulse(3, 1'b0);
    rd(8'h00, rv);
    chk("soft_rst", rv[5], 0);
    chk("osc_rst", o_low_power_rc_osc_enable, 0);
    rd(8'h08, rv);
    chk("rst_cnt", rv, 0);
    close_out();
  end
endmodule : wdtw_top_bench
`default_nettype wire
